// [sadr_pkg.sv]
// package for the system address decode router: types and constants
// assumes a single core clock domain and APB register access
package sadr_pkg;

    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_APERTURE_BASE = 12'h004;
    localparam logic [11:0] REG_APMASK = 12'h008;
    localparam logic [11:0] REG_WIN = 12'h00C;
    localparam logic [11:0] REG_PWIN = 12'h010;
    localparam logic [11:0] REG_IOWIN = 12'h014;
    localparam logic [11:0] REG_TOM = 12'h018;
    localparam logic [11:0] REG_PAM = 12'h01C;
    localparam logic [11:0] REG_STAT = 12'h020;
    localparam logic [11:0] REG_MGMT = 12'h024;

    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam logic [31:0] TOM_RST = 32'h0400_0000;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] ONES_WORD = 32'hFFFF_FFFF;

    // ctrl bit positions
    localparam int CTRL_AGP_IO_EN = 0;
    localparam int CTRL_VGA_EN = 1;
    localparam int CTRL_MDA = 2;
    localparam int CTRL_ISA_EN = 3;
    localparam int CTRL_VGA_WR_EN = 4;

    localparam logic [15:0] CFG_ADDR_PORT = 16'h0CF8;
    localparam logic [15:0] CFG_DATA_PORT = 16'h0CFC;
    localparam logic [15:0] IDE_LO = 16'h01F0;
    localparam logic [15:0] IDE_HI = 16'h01F7;
    localparam logic [31:0] VGA_MEM_LO = 32'h000A_0000;
    localparam logic [31:0] VGA_MEM_HI = 32'h000B_FFFF;
    localparam logic [31:0] MDA_MEM_LO = 32'h000B_0000;
    localparam logic [31:0] MDA_MEM_HI = 32'h000B_7FFF;
    localparam logic [31:0] COMPAT_LO = 32'h000A_0000;
    localparam logic [31:0] COMPAT_HI = 32'h000F_FFFF;
    localparam logic [9:0] VGA_IO_A_LO = 10'h3B0;
    localparam logic [9:0] VGA_IO_A_HI = 10'h3BB;
    localparam logic [9:0] VGA_IO_B_LO = 10'h3C0;
    localparam logic [9:0] VGA_IO_B_HI = 10'h3DF;
    localparam logic [9:0] MDA_IO_LO = 10'h3BC;
    localparam logic [9:0] MDA_IO_HI = 10'h3BF;
    localparam logic [31:0] REMAP_ADDR = 32'h0000_0000;
    localparam logic [11:0] PAGE_MASK = 12'hFFF;
    localparam int HUB_MAX_BYTES = 256;
    localparam int AGP_BLOCK_BYTES = 32;

    typedef enum logic [1:0]
    {
        SRC_HOST = 2'h0,
        SRC_HUB = 2'h1,
        SRC_AGP_PCI = 2'h2,
        SRC_AGP_PIPE = 2'h3
    } sadr_src_t;

    typedef enum logic [1:0]
    {
        CYC_MEM = 2'h0,
        CYC_IO = 2'h1,
        CYC_SPECIAL = 2'h2,
        CYC_CONFIG = 2'h3
    } sadr_cyc_t;

    typedef enum logic [2:0]
    {
        DST_NONE = 3'h0,
        DST_DRAM = 3'h1,
        DST_HUB = 3'h2,
        DST_AGP = 3'h3,
        DST_INTERNAL = 3'h4,
        DST_ABORT = 3'h5
    } sadr_dst_t;

    typedef struct packed
    {
        sadr_src_t src;
        sadr_cyc_t cyc;
        logic write;
        logic needs_cpl;
        logic io_wrap;
        logic [31:0] addr;
        logic [8:0] len;
    } sadr_req_t;

    typedef struct packed
    {
        sadr_dst_t dst;
        logic claim;
        logic snoop;
        logic be_off;
        logic rd_ones;
        logic master_abort;
        logic posted;
        logic [31:0] addr;
        logic [8:0] len;
    } sadr_rsp_t;

endpackage

// [sadr_req_model.sv]
// requester model standing for the host, hub and agp masters
// assumes the router takes requests on the core clock rising edge
`timescale 1ns/1ps
`default_nettype none
module sadr_req_model
(
    input wire logic CORE_CLK,
    input wire logic REQ_READY,
    input wire logic RSP_VALID,
    input wire sadr_pkg::sadr_rsp_t RSP,
    input wire logic RSP_LAST,
    input wire logic AGP_DISCONNECT,
    output logic REQ_VALID,
    output sadr_pkg::sadr_req_t REQ
);
    sadr_pkg::sadr_rsp_t rsp_q[$];
    logic [1:0] tag_q[$];
    initial
    begin
        REQ_VALID = 1'b0;
        REQ = '0;
    end
    // every part is kept with its disconnect and last marks
    always @(posedge CORE_CLK)
    begin
        if (RSP_VALID === 1'b1)
        begin
            rsp_q.push_back(RSP);
            tag_q.push_back({AGP_DISCONNECT, RSP_LAST});
        end
    end
    // request held until the rising edge at which ready is seen high, for at most 20 edges
    task automatic send(input sadr_pkg::sadr_req_t r, output logic ok);
        int n;
        ok = 1'b0;
        REQ_VALID <= 1'b1;
        REQ <= r; // callers keep pipelined lengths within 256
        for (n = 0; n < 20 && !ok; n++)
        begin
            @(posedge CORE_CLK);
            ok = (REQ_READY === 1'b1);
        end
        REQ_VALID <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sadr_router.sv]
// address decode and routing for host, hub and agp requests
// assumes requests arrive on the core clock, one per valid/ready handshake
//
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module sadr_router
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire sadr_pkg::sadr_req_t REQ,
    output logic RSP_VALID,
    output sadr_pkg::sadr_rsp_t RSP,
    output logic RSP_LAST,
    output logic AGP_DISCONNECT,
    output logic INVALID_AGP_ACCESS_FLAG
);

    logic [31:0] ctrl_q;
    logic [31:0] aperture_base_q;
    logic [31:0] apmask_q;
    logic [31:0] win_q;
    logic [31:0] pwin_q;
    logic [31:0] iowin_q;
    logic [31:0] tom_q;
    logic [31:0] pam_q;
    logic [31:0] mgmt_q;
    logic flag_q;
    logic busy_q;
    sadr_pkg::sadr_req_t cur_q;
    sadr_pkg::sadr_dst_t start_q;
    logic [8:0] left_q;

    // window register: upper half limit, lower half base, 1 MB units
    // limit is exclusive so that a cleared window is empty after reset
    function automatic logic in_win(input logic [31:0] w,
                                    input logic [31:0] a);
        in_win = (a[31:20] >= w[11:0]) && (a[31:20] < w[27:16]);
    endfunction

    function automatic logic io_in(input logic [9:0] a,
                                   input logic [9:0] lo,
                                   input logic [9:0] hi);
        io_in = (a >= lo) && (a <= hi);
    endfunction

    function automatic logic mda_port(input logic [9:0] p);
        mda_port = io_in(p, 10'h3B4, 10'h3B5) || io_in(p, 10'h3B8, 10'h3BA)
                   || (p == 10'h3BF);
    endfunction

    // ---------------- apb slave ----------------
    wire apb_acc = PSEL && PENABLE;
    wire apb_wr = apb_acc && PWRITE;
    logic [31:0] rd_mux;
    logic hit;

    always_comb
    begin
        hit = 1'b1;
        unique case (PADDR)
            sadr_pkg::REG_CTRL: rd_mux = ctrl_q;
            sadr_pkg::REG_APERTURE_BASE: rd_mux = aperture_base_q;
            sadr_pkg::REG_APMASK: rd_mux = apmask_q;
            sadr_pkg::REG_WIN: rd_mux = win_q;
            sadr_pkg::REG_PWIN: rd_mux = pwin_q;
            sadr_pkg::REG_IOWIN: rd_mux = iowin_q;
            sadr_pkg::REG_TOM: rd_mux = tom_q;
            sadr_pkg::REG_PAM: rd_mux = pam_q;
            sadr_pkg::REG_STAT: rd_mux = {30'h0, busy_q, flag_q};
            sadr_pkg::REG_MGMT: rd_mux = mgmt_q;
            default:
            begin
                rd_mux = sadr_pkg::ZERO_WORD;
                hit = 1'b0;
            end
        endcase
    end

    assign PREADY = 1'b1;
    assign PSLVERR = apb_acc && !hit;

    wire clr_flag = apb_wr && (PADDR == sadr_pkg::REG_STAT) && PWDATA[0];

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            ctrl_q <= sadr_pkg::CTRL_RST;
            aperture_base_q <= sadr_pkg::ZERO_WORD;
            apmask_q <= sadr_pkg::ONES_WORD;
            win_q <= sadr_pkg::ZERO_WORD;
            pwin_q <= sadr_pkg::ZERO_WORD;
            iowin_q <= sadr_pkg::ZERO_WORD;
            tom_q <= sadr_pkg::TOM_RST;
            pam_q <= sadr_pkg::ZERO_WORD;
            mgmt_q <= sadr_pkg::ZERO_WORD;
            PRDATA <= sadr_pkg::ZERO_WORD;
        end
        else
        begin
            if (PSEL && !PENABLE && !PWRITE)
                PRDATA <= rd_mux;
            if (apb_wr)
            begin
                unique case (PADDR)
                    sadr_pkg::REG_CTRL: ctrl_q <= PWDATA;
                    sadr_pkg::REG_APERTURE_BASE: aperture_base_q <= PWDATA;
                    sadr_pkg::REG_APMASK: apmask_q <= PWDATA;
                    sadr_pkg::REG_WIN: win_q <= PWDATA;
                    sadr_pkg::REG_PWIN: pwin_q <= PWDATA;
                    sadr_pkg::REG_IOWIN: iowin_q <= PWDATA;
                    sadr_pkg::REG_TOM: tom_q <= PWDATA;
                    sadr_pkg::REG_PAM: pam_q <= PWDATA;
                    sadr_pkg::REG_MGMT: mgmt_q <= PWDATA;
                    default: ;
                endcase
            end
        end
    end

    // ---------------- decode ----------------
    wire vga_en = ctrl_q[sadr_pkg::CTRL_VGA_EN];
    wire mda_en = ctrl_q[sadr_pkg::CTRL_MDA];
    wire isa_en = ctrl_q[sadr_pkg::CTRL_ISA_EN];
    wire agp_io_en = ctrl_q[sadr_pkg::CTRL_AGP_IO_EN];
    wire vga_wr_en = ctrl_q[sadr_pkg::CTRL_VGA_WR_EN];

    // the active request: a new one or the remaining part of a split one
    wire sadr_pkg::sadr_req_t rq = busy_q ? cur_q : REQ;
    wire [31:0] a = rq.addr;
    wire [16:0] io_a = {rq.io_wrap, a[15:0]};
    wire [9:0] a10 = a[9:0];

    wire is_compat = (a >= sadr_pkg::COMPAT_LO) && (a <= sadr_pkg::COMPAT_HI);
    wire is_mgmt = in_win(mgmt_q, a);
    wire is_dram = (a < tom_q) && !is_mgmt;
    wire is_aper = ((a ^ aperture_base_q) & apmask_q) == sadr_pkg::ZERO_WORD;
    wire is_agpwin = in_win(win_q, a) || in_win(pwin_q, a);
    wire is_vga_mem = (a >= sadr_pkg::VGA_MEM_LO) &&
                      (a <= sadr_pkg::VGA_MEM_HI);
    wire is_mda_mem = (a >= sadr_pkg::MDA_MEM_LO) &&
                      (a <= sadr_pkg::MDA_MEM_HI);
    wire pam_rd = pam_q[{a[18:16], 1'b0}];
    wire pam_wr = pam_q[{a[18:16], 1'b1}];

    // vga and mono io decode, aliases ignored above bit 9; config, disk and window ports use all 16 bits
    wire [9:0] io_last = a10 + 10'(rq.len[2:0]) - 10'h1;
    // host io is at most four bytes; only its two ends are checked, so a span over 3B4-3B5 or 3BF with both ends outside is missed
    wire io_mda = mda_port(a10) || mda_port(io_last);
    wire io_vga = io_in(a10, sadr_pkg::VGA_IO_A_LO, sadr_pkg::VGA_IO_A_HI) ||
                  io_in(a10, sadr_pkg::VGA_IO_B_LO, sadr_pkg::VGA_IO_B_HI);
    wire io_3bc = io_in(a10, sadr_pkg::MDA_IO_LO, sadr_pkg::MDA_IO_HI);
    wire io_win = (io_a[15:0] >= iowin_q[15:0]) &&
                  (io_a[15:0] <= iowin_q[31:16]) && !io_a[16];
    wire io_cfg = (io_a[15:0] == sadr_pkg::CFG_ADDR_PORT) ||
                  (io_a[15:0] == sadr_pkg::CFG_DATA_PORT);
    wire io_ide = (io_a[15:0] >= sadr_pkg::IDE_LO) &&
                  (io_a[15:0] <= sadr_pkg::IDE_HI);

    // host io: mono first, then vga, then x3BC block, then window
    logic host_io_agp;
    always_comb
    begin
        if (mda_en && vga_en && io_mda)
            host_io_agp = 1'b0;
        else if (vga_en && io_vga)
            host_io_agp = 1'b1;
        else if (io_3bc)
            host_io_agp = !vga_en && io_win && !isa_en;
        else
            host_io_agp = io_win && !(isa_en && a[9:8] != 2'b00);
    end

    // host memory: vga enable overrides the windows only in the vga range
    wire host_mem_agp = (is_vga_mem && vga_en) ? !(mda_en && is_mda_mem)
                                               : is_agpwin;

    // block size for split hub and agp requests
    wire blk64 = rq.len > 9'd32;
    wire [8:0] blk = (rq.src == sadr_pkg::SRC_AGP_PIPE || !blk64)
                     ? 9'(sadr_pkg::AGP_BLOCK_BYTES) : 9'd64;
    wire [8:0] to_edge = blk - {3'h0, a[5:0] & (blk[5:0] - 6'h1)};
    wire [8:0] seg = (rq.len < to_edge) ? rq.len : to_edge;
    wire [12:0] pg_left = 13'h1000 - {1'b0, a[11:0]};
    wire pg_cut = {4'h0, rq.len} > pg_left;

    // per-part classification of the current address
    logic hub_ok;
    always_comb
    begin
        hub_ok = (is_dram && !is_vga_mem) || is_aper ||
                 (rq.write && is_agpwin) ||
                 (rq.write && vga_wr_en && vga_en && is_vga_mem);
    end
    wire sadr_pkg::sadr_dst_t hub_dst =
        !hub_ok ? sadr_pkg::DST_NONE
        : ((is_dram && !is_vga_mem) || is_aper) ? sadr_pkg::DST_DRAM
        : sadr_pkg::DST_AGP;
    wire agp_valid = (is_dram && !is_compat) || is_aper;

    sadr_pkg::sadr_rsp_t r;
    logic split;
    always_comb
    begin
        r = '0;
        r.addr = a;
        r.len = rq.len;
        split = 1'b0;
        unique case (rq.src)
            sadr_pkg::SRC_HOST:
            begin
                r.claim = 1'b1;
                if (rq.cyc == sadr_pkg::CYC_IO)
                begin
                    r.addr = {15'h0, io_a};
                    if (io_cfg)
                        r.dst = sadr_pkg::DST_INTERNAL;
                    else if (host_io_agp && agp_io_en)
                        r.dst = sadr_pkg::DST_AGP;
                    else
                        r.dst = sadr_pkg::DST_HUB;
                    r.posted = rq.write && !io_ide;
                end
                else if (host_mem_agp)
                    r.dst = sadr_pkg::DST_AGP;
                else if (is_dram && !(is_vga_mem))
                    r.dst = sadr_pkg::DST_DRAM;
                else
                    r.dst = sadr_pkg::DST_HUB;
            end
            sadr_pkg::SRC_HUB:
            begin
                r.claim = 1'b1;
                if (rq.cyc != sadr_pkg::CYC_MEM)
                begin
                    r.dst = sadr_pkg::DST_ABORT;
                    r.master_abort = 1'b1;
                end
                else
                begin
                    split = rq.len > seg;
                    r.len = seg;
                    // bad part: an invalid part, a start that was invalid, or a change of target
                    if (hub_dst == sadr_pkg::DST_NONE ||
                        (busy_q && hub_dst != start_q) ||
                        (busy_q && start_q == sadr_pkg::DST_NONE))
                    begin
                        r.dst = sadr_pkg::DST_DRAM;
                        r.addr = sadr_pkg::REMAP_ADDR;
                        r.snoop = 1'b1;
                        r.rd_ones = !rq.write;
                        r.be_off = rq.write;
                        r.master_abort = !rq.write || rq.needs_cpl;
                    end
                    else
                    begin
                        r.dst = hub_dst;
                        r.snoop = hub_dst == sadr_pkg::DST_DRAM;
                    end
                end
            end
            sadr_pkg::SRC_AGP_PCI:
            begin
                // io, special and config are left unclaimed
                if (rq.cyc == sadr_pkg::CYC_MEM &&
                    (is_dram || is_aper) &&
                    (!is_compat || (rq.write ? pam_wr : pam_rd)))
                begin
                    r.claim = 1'b1;
                    r.dst = sadr_pkg::DST_DRAM;
                    if (pg_cut)
                        r.len = pg_left[8:0];
                end
            end
            default:
            begin
                r.claim = 1'b1;
                r.dst = sadr_pkg::DST_DRAM;
                split = rq.len > seg;
                r.len = seg;
                if (!agp_valid)
                begin
                    r.addr = sadr_pkg::REMAP_ADDR;
                    r.be_off = rq.write;
                end
            end
        endcase
    end

    wire take = REQ_VALID && !busy_q;
    wire fire = take || busy_q;
    wire agp_bad = fire && rq.src == sadr_pkg::SRC_AGP_PIPE && !agp_valid;

    assign REQ_READY = !busy_q;

    always_ff @(posedge CORE_CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            busy_q <= 1'b0;
            cur_q <= '0;
            start_q <= sadr_pkg::DST_NONE;
            left_q <= 9'h0;
            RSP_VALID <= 1'b0;
            RSP <= '0;
            RSP_LAST <= 1'b0;
            AGP_DISCONNECT <= 1'b0;
            flag_q <= 1'b0;
        end
        else
        begin
            RSP_VALID <= fire;
            RSP_LAST <= fire && !split;
            AGP_DISCONNECT <= fire && rq.src == sadr_pkg::SRC_AGP_PCI &&
                              r.claim && pg_cut;
            if (fire)
                RSP <= r;
            if (fire && split)
            begin
                busy_q <= 1'b1;
                cur_q <= rq;
                cur_q.addr <= a + {23'h0, seg};
                cur_q.len <= rq.len - seg;
                if (!busy_q)
                    start_q <= (rq.src == sadr_pkg::SRC_HUB) ? hub_dst
                                                             : sadr_pkg::DST_DRAM;
            end
            else if (fire)
                busy_q <= 1'b0;
            // a new error wins over a software clear in the same cycle
            if (agp_bad)
                flag_q <= 1'b1;
            else if (clr_flag)
                flag_q <= 1'b0;
        end
    end

    assign INVALID_AGP_ACCESS_FLAG = flag_q;

    // ---------------- assertions ----------------
    property p_agp_io_silent;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_AGP_PCI &&
         REQ.cyc != sadr_pkg::CYC_MEM) |=> (RSP_VALID && !RSP.claim);
    endproperty
    a_agp_io_silent: assert property (p_agp_io_silent)
        else $error("agp io cycle was claimed");

    property p_hub_io_abort;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_HUB && REQ.cyc == sadr_pkg::CYC_IO)
        |=> (RSP.master_abort && RSP.dst == sadr_pkg::DST_ABORT);
    endproperty
    a_hub_io_abort: assert property (p_hub_io_abort)
        else $error("hub io not master aborted");

    property p_cfg_internal;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_HOST &&
         REQ.cyc == sadr_pkg::CYC_IO && io_cfg)
        |=> RSP.dst == sadr_pkg::DST_INTERNAL;
    endproperty
    a_cfg_internal: assert property (p_cfg_internal)
        else $error("config port not internal");

    property p_io_untranslated;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_HOST && REQ.cyc == sadr_pkg::CYC_IO)
        |=> RSP.addr[16:0] == $past({REQ.io_wrap, REQ.addr[15:0]});
    endproperty
    a_io_untranslated: assert property (p_io_untranslated)
        else $error("io address translated");

    property p_ide_not_posted;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_HOST && REQ.cyc == sadr_pkg::CYC_IO
         && io_ide) |=> !RSP.posted;
    endproperty
    a_ide_not_posted: assert property (p_ide_not_posted)
        else $error("disk io write posted");

    property p_agp_io_off;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (take && REQ.src == sadr_pkg::SRC_HOST && !agp_io_en &&
         REQ.cyc == sadr_pkg::CYC_IO) |=> RSP.dst != sadr_pkg::DST_AGP;
    endproperty
    a_agp_io_off: assert property (p_agp_io_off)
        else $error("io routed to disabled agp");

    property p_flag_sticky;
        @(posedge CORE_CLK) disable iff (!RST_N)
        agp_bad |=> flag_q ##1 (flag_q || $past(clr_flag));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("invalid access flag lost");

    property p_agp_no_snoop;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (fire && rq.src[1]) |=> !RSP.snoop;
    endproperty
    a_agp_no_snoop: assert property (p_agp_no_snoop)
        else $error("agp cycle snooped");

    property p_pipe_block;
        @(posedge CORE_CLK) disable iff (!RST_N)
        (fire && rq.src == sadr_pkg::SRC_AGP_PIPE)
        |=> RSP.len <= 9'(sadr_pkg::AGP_BLOCK_BYTES);
    endproperty
    a_pipe_block: assert property (p_pipe_block)
        else $error("pipelined part exceeds block");

endmodule

`default_nettype wire

// [system_address_decode_router_tb.sv]
// self-checking bench for the address decode router
// assumes the requester model of sadr_req_model.sv on the request side
`timescale 1ns/1ps
`default_nettype none
module system_address_decode_router_tb;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, er, req_valid, req_ready, rsp_valid, rsp_last;
    logic agp_disc, iaa_flag;
    sadr_pkg::sadr_req_t req;
    sadr_pkg::sadr_rsp_t rsp_w, rsp;
    int n_errors = 0;
    int checked = 0;
    sadr_router dut_u
    (
        .CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .REQ_VALID(req_valid), .REQ_READY(req_ready),
        .REQ(req), .RSP_VALID(rsp_valid), .RSP(rsp_w), .RSP_LAST(rsp_last),
        .AGP_DISCONNECT(agp_disc), .INVALID_AGP_ACCESS_FLAG(iaa_flag)
    );
    sadr_req_model req_u
    (
        .CORE_CLK(core_clk), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP(rsp_w), .RSP_LAST(rsp_last), .AGP_DISCONNECT(agp_disc),
        .REQ_VALID(req_valid), .REQ(req)
    );
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge core_clk);
            if (pready === 1'b1)
            begin
                rd = prdata;
                er = pslverr;
                break;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            n_errors++;
            finish_test();
        end
    endtask
    // k packs {src, cyc, write}; ten cycles cover the longest split
    task automatic go(input logic [4:0] k, input logic [31:0] a,
        input logic [8:0] l);
        sadr_pkg::sadr_req_t r;
        logic ok;
        req_u.rsp_q.delete();
        req_u.tag_q.delete();
        r.src = sadr_pkg::sadr_src_t'(k[4:3]);
        r.cyc = sadr_pkg::sadr_cyc_t'(k[2:1]);
        r.write = k[0];
        r.needs_cpl = 1'b1;
        r.io_wrap = ({1'b0, a[15:0]} + {8'h0, l}) > 17'h1_0000;
        r.addr = a;
        r.len = l;
        req_u.send(r, ok);
        repeat (10) @(posedge core_clk);
        if (!ok)
        begin
            n_errors++;
            finish_test();
        end
        rsp = (req_u.rsp_q.size() > 0) ? req_u.rsp_q[0] : '1;
    endtask
    task automatic t_regs();
        apb(1'b0, sadr_pkg::REG_CTRL, 32'h0);
        chk(rd, sadr_pkg::CTRL_RST);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({er, rd[0]}, 2'h2);
    endtask
    task automatic t_host_io();
        go(5'h02, 32'h0000_0CF8, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_INTERNAL);
        go(5'h03, 32'h0000_01F0, 9'h001);
        chk({rsp.dst, rsp.posted}, {sadr_pkg::DST_HUB, 1'b0});
        go(5'h02, 32'h0000_FFFD, 9'h004);
        chk(rsp.addr, 32'h0001_FFFD);
        apb(1'b1, sadr_pkg::REG_IOWIN, 32'h1FFF_1000);
        go(5'h02, 32'h0000_1004, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_AGP);
        apb(1'b1, sadr_pkg::REG_CTRL, 32'h0);
        go(5'h02, 32'h0000_1004, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_HUB);
    endtask
    task automatic t_hub();
        go(5'h0A, 32'h0000_0080, 9'h004);
        chk(rsp.master_abort, 1'b1);
        go(5'h09, 32'h0000_1000, 9'h004);
        chk({rsp.dst, rsp.be_off, rsp.master_abort}, 5'h04);
        go(5'h08, 32'h0000_0020, 9'h040);
        chk(req_u.rsp_q.size(), 2);
        chk(req_u.rsp_q[1].addr, 32'h0000_0040);
        chk({rsp.len, req_u.tag_q[1]}, {9'h020, 2'h1});
        go(5'h08, 32'h03FF_FFE0, 9'h040);
        chk(rsp.rd_ones, 1'b0);
        chk(req_u.rsp_q[1].addr, sadr_pkg::REMAP_ADDR);
        chk(req_u.rsp_q[1].rd_ones, 1'b1);
        go(5'h08, 32'hF000_0000, 9'h004);
        chk(rsp.addr, sadr_pkg::REMAP_ADDR);
        chk({rsp.dst, rsp.snoop, rsp.rd_ones, rsp.master_abort}, 6'h0F);
    endtask
    task automatic t_agp();
        go(5'h12, 32'h0000_0080, 9'h004);
        chk(rsp.claim, 1'b0);
        go(5'h16, 32'h0000_0080, 9'h004);
        chk(rsp.claim, 1'b0);
        go(5'h10, 32'h0000_1000, 9'h004);
        chk({rsp.claim, rsp.snoop}, 2'h2);
        go(5'h10, 32'h1000_0000, 9'h004);
        chk(rsp.claim, 1'b0);
        apb(1'b1, sadr_pkg::REG_PAM, 32'h0);
        go(5'h11, 32'h000C_0000, 9'h004);
        chk(rsp.claim, 1'b0);
        apb(1'b1, sadr_pkg::REG_PAM, 32'hFFFF_FFFF);
        go(5'h11, 32'h000C_0000, 9'h004);
        chk(rsp.claim, 1'b1);
        go(5'h10, 32'h0000_0FE0, 9'h040);
        chk({req_u.tag_q[0][1], rsp.len}, {1'b1, 9'h020});
        go(5'h10, 32'h0000_1000, 9'h020); // resume at new page
        chk(rsp.claim, 1'b1);
        go(5'h18, 32'h0000_1000, 9'h040);
        chk(req_u.rsp_q.size(), 2);
        go(5'h19, 32'hF000_0000, 9'h020);
        chk(rsp.addr, sadr_pkg::REMAP_ADDR);
        chk({rsp.be_off, iaa_flag}, 2'h3);
        apb(1'b1, sadr_pkg::REG_STAT, 32'h1);
        @(posedge core_clk);
        chk(iaa_flag, 1'b0);
    endtask
    task automatic t_vga();
        apb(1'b1, sadr_pkg::REG_CTRL, 32'h7);
        go(5'h00, 32'h000A_0000, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_AGP);
        go(5'h02, 32'h0000_FFC0, 9'h001);
        chk(rsp.dst, sadr_pkg::DST_AGP);
        go(5'h02, 32'h0000_03BC, 9'h001);
        chk(rsp.dst, sadr_pkg::DST_HUB);
        go(5'h02, 32'h0000_03B6, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_HUB);
        go(5'h00, 32'h000B_0000, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_HUB);
        apb(1'b1, sadr_pkg::REG_CTRL, 32'h1);
        go(5'h00, 32'h000A_0000, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_HUB);
        go(5'h02, 32'h0000_13BC, 9'h001);
        chk(rsp.dst, sadr_pkg::DST_AGP);
        apb(1'b1, sadr_pkg::REG_CTRL, 32'h12);
        go(5'h09, 32'h000A_0000, 9'h004);
        chk(rsp.dst, sadr_pkg::DST_AGP);
    endtask
    initial
    begin
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        t_regs();
        t_host_io();
        t_hub();
        t_agp();
        t_vga();
        finish_test();
    end
endmodule
`default_nettype wire
